// file: rtl/flash_cache_map.svh
// Purpose: Register offsets, field positions and reset values of the write-cache control block
// Assumes: Included by the package user; byte-wide registers, 9-bit byte index
// Notes:   Definitions only
`ifndef FLASH_CACHE_MAP_SVH
`define FLASH_CACHE_MAP_SVH

// Byte indices in the extended configuration space
`define OFF_FENCE_EN    9'h01F
`define OFF_FLUSH_TRIG  9'h020
`define OFF_CACHE_CTRL  9'h021
`define OFF_POLICY      9'h0F0
`define OFF_FENCE_CAP   9'h1E6
// Block-local registers
`define OFF_IRQ_STAT    9'h100
`define OFF_IRQ_CLR     9'h101
`define OFF_IRQ_EN      9'h102
`define OFF_STATE       9'h103
`define OFF_ENH_MULT    9'h104

// Field positions
`define BIT_FENCE_EN    0
`define BIT_FLUSH       0
`define BIT_FENCE       1
`define BIT_CACHE_ON    0
`define BIT_FIFO        0

// Interrupt event positions
`define IRQ_FLUSH_DONE  0
`define IRQ_FENCE_DONE  1
`define IRQ_COMMIT_ERR  2
`define IRQ_FENCE_OVF   3

// Reset values and fixed contents
`define RST_BYTE        8'h00
`define POLICY_VALUE    8'h01
`define ENH_UNIT_KB     40'h0000000200

`endif

// file: rtl/flash_cache_pkg.sv
// Purpose: Types shared by the write-cache control block
// Assumes: Nothing
// Notes:   Constants live in flash_cache_map.svh
package flash_cache_pkg;
  // Commit channel state, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } commit_st_t;
  // Interrupt event vector
  typedef logic [3:0] irq_vec_t;
endpackage

// file: rtl/flash_write_cache.sv
// Purpose: Write-cache control: enable, flush, ordering fences, commit channel, status
// Assumes: Link signals come from the card-bus clock domain and change on its falling edge
// Notes:   Cached entries commit in arrival order; forced writes bypass the cache and commit ahead of them
`timescale 1ns/1ps
`default_nettype none
`include "flash_cache_map.svh"

module flash_write_cache
  import flash_cache_pkg::*;
#(
  parameter int         DEPTH       = 16,     // Cache entries
  parameter int         TAG_W       = 8,      // Request tag width
  parameter int         FENCE_LIMIT = 8,      // Fences absorbed before a full flush
  parameter logic       FENCE_SUP   = 1'b1,   // Fence function present
  parameter logic [7:0] WP_GRP      = 8'h01,  // Write-protect group size
  parameter logic [7:0] ERASE_GRP   = 8'h01,  // Erase group size
  parameter logic [7:0] MAX_MULT    = 8'h10   // Largest enhanced area multiplier
) (
  input  wire logic             i_ref_clk,     // Device clock
  input  wire logic             i_sys_rst,     // Synchronous reset, high
  input  wire logic [8:0]       i_addr,        // Register byte index
  input  wire logic [7:0]       i_wr_data,     // Write data
  input  wire logic             i_wr_stb,      // Write strobe
  input  wire logic             i_rd_stb,      // Read strobe
  output logic      [7:0]       o_rd_data,     // Read data, cycle after strobe
  input  wire logic             i_link_clk,    // Card-bus clock, sampled
  input  wire logic             i_hw_rst_n,    // Hardware reset pin, low active
  input  wire logic             i_cmd0,        // Go-idle command seen, link domain
  input  wire logic             i_wr_req,      // Write request, link domain
  input  wire logic [TAG_W-1:0] i_wr_tag,      // Request tag
  input  wire logic             i_wr_force,    // Forced or reliable write
  output logic                  o_link_busy,   // Holding slot occupied
  output logic                  o_commit_valid,// Commit to media valid
  output logic      [TAG_W-1:0] o_commit_tag,  // Tag being committed
  output logic                  o_commit_direct,// Commit bypasses the cache
  input  wire logic             i_commit_ready,// Media takes commit
  input  wire logic             i_commit_err,  // Media error with ready
  output logic                  o_cache_err,   // Sticky commit error
  output logic                  o_irq,         // Level interrupt
  output logic      [39:0]      o_enh_size_kb, // Enhanced area size
  output logic      [39:0]      o_enh_max_kb   // Largest enhanced area size
);

  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int FCN_W = $clog2(FENCE_LIMIT + 1);
  localparam logic [CNT_W-1:0] FULL_CNT  = CNT_W'(DEPTH);
  localparam logic [FCN_W-1:0] FENCE_MAX = FCN_W'(FENCE_LIMIT);  // Count after LIMIT absorbed fences
  localparam logic [PTR_W-1:0] LAST_PTR  = PTR_W'(DEPTH - 1);

  // Enhanced area size in KBytes
  function automatic logic [39:0] size_kb(input logic [7:0] mult);
    size_kb = 40'(mult) * 40'(WP_GRP) * 40'(ERASE_GRP) * `ENH_UNIT_KB;
  endfunction

  // Next pointer with wrap
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  // Synchronisers for link-domain inputs
  logic [2:0]       lclk_s;                    // Link clock, third stage for edges
  logic [1:0]       req_s;                     // Request level
  logic [1:0]       force_s;                   // Force flag
  logic [1:0]       cmd0_s;                    // Go-idle flag
  logic [1:0]       hwrst_s;                   // Reset pin
  logic [TAG_W-1:0] tag_s0;                    // Tag first stage
  logic [TAG_W-1:0] tag_s1;                    // Tag second stage

  // Control state
  logic             cache_en_r;                // Cache switched on
  logic             fence_en_r;                // Host enabled fences
  logic             flush_act_r;               // Full flush running
  logic [FCN_W-1:0] fence_cnt_r;               // Fences since last flush
  logic             err_r;                     // Sticky commit error
  logic [7:0]       enh_mult_r;                // Enhanced area multiplier
  irq_vec_t         irq_stat_r;                // Sticky events
  irq_vec_t         irq_en_r;                  // Event enables
  commit_st_t       state_r;                   // Commit channel state

  // Holding slot and cache array
  logic             pend_v_r;                  // Slot holds a request
  logic [TAG_W-1:0] pend_tag_r;                // Held tag
  logic             pend_force_r;              // Held force flag
  logic [TAG_W-1:0] mem [DEPTH];               // Cached tags
  logic [PTR_W-1:0] rd_ptr_r;                  // Oldest entry
  logic [PTR_W-1:0] wr_ptr_r;                  // Next free entry
  logic [CNT_W-1:0] count_r;                   // Entries held

  // Decoded events
  logic link_rise;                             // Rising card-bus edge
  logic req_take;                              // Request accepted into slot
  logic hw_off;                                // Reset pin or CMD0 turns cache off
  logic wr_ctrl;                               // Write to enable byte
  logic wr_trig;                               // Write to flush trigger byte
  logic fence_ok;                              // Fence has effect
  logic fence_evt;                             // Fence performed
  logic fence_ovf;                             // Fence over limit
  logic flush_req;                             // Flush starts
  logic flush_done;                            // Flush finished
  logic chan_free;                             // Channel can take a commit
  logic drain;                                 // Cache must empty
  logic full;                                  // Cache full
  logic issue_force;                           // Forced write to media
  logic issue_pop;                             // Oldest cached entry to media
  logic issue_direct;                          // Uncached write to media
  logic do_push;                               // Slot into cache
  logic commit_acc;                            // Media took commit
  irq_vec_t irq_set;                           // Events this cycle
  logic [7:0] rd_nxt;                          // Read data next

  // Two flip-flops on every input from the link domain, three on the link clock
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      lclk_s  <= '0;
      req_s   <= '0;
      force_s <= '0;
      cmd0_s  <= '0;
      hwrst_s <= 2'h3;
      tag_s0  <= '0;
      tag_s1  <= '0;
    end else begin
      lclk_s  <= {lclk_s[1:0], i_link_clk};
      req_s   <= {req_s[0], i_wr_req};
      force_s <= {force_s[0], i_wr_force};
      cmd0_s  <= {cmd0_s[0], i_cmd0};
      hwrst_s <= {hwrst_s[0], i_hw_rst_n};
      tag_s0  <= i_wr_tag;
      tag_s1  <= tag_s0;
    end
  end

  // Event decode
  assign link_rise  = lclk_s[1] & ~lclk_s[2];
  assign req_take   = link_rise & req_s[1] & ~pend_v_r;
  assign hw_off     = ~hwrst_s[1] | (link_rise & cmd0_s[1]);
  assign wr_ctrl    = i_wr_stb & (i_addr == `OFF_CACHE_CTRL);
  assign wr_trig    = i_wr_stb & (i_addr == `OFF_FLUSH_TRIG);
  assign fence_ok   = FENCE_SUP & fence_en_r;
  assign fence_evt  = wr_trig & i_wr_data[`BIT_FENCE] & fence_ok;
  assign fence_ovf  = fence_evt & (fence_cnt_r == FENCE_MAX);
  assign flush_req  = (cache_en_r & ((wr_ctrl & ~i_wr_data[`BIT_CACHE_ON]) | hw_off))
                    | (wr_trig & i_wr_data[`BIT_FLUSH]) | fence_ovf;
  assign full       = (count_r == FULL_CNT);
  assign commit_acc = o_commit_valid & i_commit_ready;
  assign chan_free  = ~o_commit_valid | i_commit_ready;
  assign drain      = flush_act_r | ~cache_en_r | full;
  assign issue_force  = chan_free & pend_v_r & pend_force_r;
  assign issue_pop    = chan_free & ~issue_force & drain & (count_r != '0);
  assign issue_direct = chan_free & pend_v_r & ~pend_force_r & ~cache_en_r
                      & (count_r == '0) & ~issue_pop;
  assign do_push    = pend_v_r & ~pend_force_r & cache_en_r & ~flush_act_r & ~full;
  assign flush_done = flush_act_r & (count_r == '0) & ~o_commit_valid;

  // Cache on/off, switched only by the enable byte; reset sources force it off
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cache_en_r <= 1'b0;
    end else if (hw_off) begin
      cache_en_r <= 1'b0;
    end else if (wr_ctrl) begin
      cache_en_r <= i_wr_data[`BIT_CACHE_ON];
    end
  end

  // Fence enable byte, bit 0 only
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      fence_en_r <= 1'b0;
    end else if (i_wr_stb && i_addr == `OFF_FENCE_EN) begin
      fence_en_r <= i_wr_data[`BIT_FENCE_EN];
    end
  end

  // Flush in progress; a new request wins over completion
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      flush_act_r <= 1'b0;
    end else if (flush_req) begin
      flush_act_r <= 1'b1;
    end else if (flush_done) begin
      flush_act_r <= 1'b0;
    end
  end

  // Fence counter; fences only count toward the limit, forced writes still commit ahead of cached entries
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      fence_cnt_r <= '0;
    end else if (fence_ovf || flush_done) begin
      fence_cnt_r <= '0;
    end else if (fence_evt) begin
      fence_cnt_r <= fence_cnt_r + 1'b1;
    end
  end

  // Sticky commit error, cleared by a flush trigger write; set wins
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      err_r <= 1'b0;
    end else if (commit_acc && i_commit_err) begin
      err_r <= 1'b1;
    end else if (wr_trig) begin
      err_r <= 1'b0;
    end
  end

  // Holding slot for one link request
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pend_v_r     <= 1'b0;
      pend_tag_r   <= '0;
      pend_force_r <= 1'b0;
    end else if (req_take) begin
      pend_v_r     <= 1'b1;
      pend_tag_r   <= tag_s1;
      pend_force_r <= force_s[1];
    end else if (do_push || issue_force || issue_direct) begin
      pend_v_r     <= 1'b0;
    end
  end

  // Cache array write
  always_ff @(posedge i_ref_clk) begin
    if (do_push) begin
      mem[wr_ptr_r] <= pend_tag_r;
    end
  end

  // Pointers and fill level
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rd_ptr_r <= '0;
      wr_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (issue_pop) begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      if (do_push && !issue_pop) begin
        count_r <= count_r + 1'b1;
      end else if (issue_pop && !do_push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // Commit channel: hold valid until the media takes it
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_r         <= ST_IDLE;
      o_commit_tag    <= '0;
      o_commit_direct <= 1'b0;
    end else if (issue_force || issue_direct) begin
      state_r         <= ST_WAIT;
      o_commit_tag    <= pend_tag_r;
      o_commit_direct <= 1'b1;
    end else if (issue_pop) begin
      state_r         <= ST_WAIT;
      o_commit_tag    <= mem[rd_ptr_r];
      o_commit_direct <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          state_r <= ST_IDLE;
        end
        ST_WAIT: begin
          if (i_commit_ready) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
  assign o_commit_valid = state_r[1];

  // Interrupt status, enable and clear; set wins over clear
  assign irq_set[`IRQ_FLUSH_DONE] = flush_done;
  assign irq_set[`IRQ_FENCE_DONE] = fence_evt;
  assign irq_set[`IRQ_COMMIT_ERR] = commit_acc & i_commit_err;
  assign irq_set[`IRQ_FENCE_OVF]  = fence_ovf;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      irq_stat_r <= '0;
      irq_en_r   <= '0;
    end else begin
      if (i_wr_stb && i_addr == `OFF_IRQ_CLR) begin
        irq_stat_r <= (irq_stat_r & ~i_wr_data[3:0]) | irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
      if (i_wr_stb && i_addr == `OFF_IRQ_EN) begin
        irq_en_r <= i_wr_data[3:0];
      end
    end
  end

  // Enhanced area multiplier
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      enh_mult_r <= `RST_BYTE;
    end else if (i_wr_stb && i_addr == `OFF_ENH_MULT) begin
      enh_mult_r <= i_wr_data;
    end
  end

  // Read decode; write-only and unmapped bytes read zero
  always_comb begin
    rd_nxt = `RST_BYTE;
    unique case (i_addr)
      `OFF_FENCE_EN:   rd_nxt = {7'h00, fence_en_r};
      `OFF_CACHE_CTRL: rd_nxt = {7'h00, cache_en_r};
      `OFF_POLICY:     rd_nxt = `POLICY_VALUE;
      `OFF_FENCE_CAP:  rd_nxt = {7'h00, FENCE_SUP};
      `OFF_IRQ_STAT:   rd_nxt = {4'h0, irq_stat_r};
      `OFF_IRQ_EN:     rd_nxt = {4'h0, irq_en_r};
      `OFF_STATE:      rd_nxt = {5'(count_r), err_r, flush_act_r, cache_en_r};
      `OFF_ENH_MULT:   rd_nxt = enh_mult_r;
      default:         rd_nxt = `RST_BYTE;
    endcase
  end

  // Registered outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rd_data     <= '0;
      o_link_busy   <= 1'b0;
      o_cache_err   <= 1'b0;
      o_irq         <= 1'b0;
      o_enh_size_kb <= '0;
      o_enh_max_kb  <= '0;
    end else begin
      o_rd_data     <= i_rd_stb ? rd_nxt : 8'h00;
      o_link_busy   <= pend_v_r;
      o_cache_err   <= err_r;
      o_irq         <= |(irq_stat_r & irq_en_r);
      o_enh_size_kb <= size_kb(enh_mult_r);
      o_enh_max_kb  <= size_kb(MAX_MULT);
    end
  end

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_ctrl_clear;
    wr_ctrl && !i_wr_data[`BIT_CACHE_ON] && cache_en_r && !hw_off;
  endsequence
  sequence s_full_wait;
    full && chan_free && !issue_force;
  endsequence

  AST_OFF_AFTER_PIN: assert property (hw_off |=> !cache_en_r)
    else $error("cache on after reset pin or go-idle");
  AST_CTRL_ONLY_WRITE: assert property ($rose(cache_en_r) |-> $past(wr_ctrl))
    else $error("cache enabled without enable byte write");
  AST_CLEAR_FLUSHES: assert property (s_ctrl_clear |=> flush_act_r && !cache_en_r)
    else $error("clearing the enable did not start a flush");
  AST_IN_ORDER: assert property (issue_pop |=> o_commit_valid && !o_commit_direct
                                 && o_commit_tag == $past(mem[rd_ptr_r]))
    else $error("commit not the oldest cached entry");
  AST_ERR_STICKY: assert property (commit_acc && i_commit_err |=> err_r ##1 o_cache_err)
    else $error("commit error not reported");
  AST_FENCE_LIMIT: assert property (fence_ovf |=> flush_act_r && fence_cnt_r == '0)
    else $error("fence limit did not start a full flush");
  AST_CAP_READ: assert property (i_rd_stb && i_addr == `OFF_FENCE_CAP
                                 |=> o_rd_data == {7'h00, FENCE_SUP})
    else $error("capability byte wrong");
  AST_FULL_DRAIN: assert property (s_full_wait |-> issue_pop ##1 !full)
    else $error("full cache not drained");
  AST_POLICY_FIXED: assert property (i_rd_stb && i_addr == `OFF_POLICY
                                     |=> o_rd_data == `POLICY_VALUE)
    else $error("policy byte changed");
  AST_FENCE_IGNORED: assert property (wr_trig && !fence_ok && !flush_done
                                      |=> $stable(fence_cnt_r))
    else $error("disabled fence changed state");

endmodule // flash_write_cache
`default_nettype wire

// file: test/card_host_model.sv
// Purpose: Card-bus host model: link clock, write requests, idle command, reset pin
// Assumes: Link period 160 ns; link clock low and still between frames
// Notes:   Released request qualifiers show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none

module card_host_model (
  output var logic       o_link_clk,  // Link clock
  output var logic       o_hw_rst_n,  // Reset pin, low active
  output var logic       o_cmd0,      // Go-idle marker
  output var logic       o_wr_req,    // Write request
  output var logic [7:0] o_wr_tag,    // Request tag
  output var logic       o_wr_force   // Forced or reliable write
);
  // Idle levels from time zero
  initial begin
    o_link_clk = 1'b0;
    o_hw_rst_n = 1'b1;
    o_cmd0     = 1'b0;
    o_wr_req   = 1'b0;
    o_wr_tag   = 8'h00;
    o_wr_force = 1'b0;
  end

  // One link period: set up while low, rise, fall, then release
  task automatic frame(input logic req, input logic [7:0] tag, input logic frc,
                       input logic idle);
    o_wr_req   = req;
    o_wr_tag   = tag;
    o_wr_force = frc;
    o_cmd0     = idle;
    #80 o_link_clk = 1'b1;
    #80 o_link_clk = 1'b0;
    o_wr_req   = 1'b0;
    o_cmd0     = 1'b0;
    o_wr_tag   = ~tag;
    o_wr_force = ~frc;
  endtask

  // Pin pulse, long enough for the synchroniser
  task automatic pin_reset();
    o_hw_rst_n = 1'b0;
    #200 o_hw_rst_n = 1'b1;
  endtask
endmodule // card_host_model

`default_nettype wire

// file: test/tb_flash_write_cache.sv
// Purpose: Self-checking bench for the write-cache control block
// Assumes: Bench plays the media side; host model drives the link
// Notes:   Fence limit lowered to 2; group sizes 2 and 3
`timescale 1ns/1ps
`default_nettype none
`include "flash_cache_map.svh"

module tb_flash_write_cache;
  import flash_cache_pkg::*;
  logic        ref_clk, sys_rst, wr_stb, rd_stb;  // Clock, reset, strobes
  logic [8:0]  addr;                              // Register index
  logic [7:0]  wr_data, rd_data, rdata, c_tag;    // Bus data, commit tag
  logic        link_clk, hw_rst_n, cmd0, wr_req, wr_force;  // Link side
  logic [7:0]  wr_tag;                            // Link tag
  logic        link_busy, c_valid, c_direct, c_ready, c_err, cache_err, irq;
  logic [39:0] enh_size, enh_max;                 // Size outputs
  int          errors, total_checks;              // Verdict counters

  card_host_model host (.o_link_clk(link_clk), .o_hw_rst_n(hw_rst_n), .o_cmd0(cmd0),
    .o_wr_req(wr_req), .o_wr_tag(wr_tag), .o_wr_force(wr_force));

  flash_write_cache #(.FENCE_LIMIT(2), .WP_GRP(8'h02), .ERASE_GRP(8'h03)) DUT (
    .i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_addr(addr), .i_wr_data(wr_data),
    .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .o_rd_data(rd_data), .i_link_clk(link_clk),
    .i_hw_rst_n(hw_rst_n), .i_cmd0(cmd0), .i_wr_req(wr_req), .i_wr_tag(wr_tag),
    .i_wr_force(wr_force), .o_link_busy(link_busy), .o_commit_valid(c_valid),
    .o_commit_tag(c_tag), .o_commit_direct(c_direct), .i_commit_ready(c_ready),
    .i_commit_err(c_err), .o_cache_err(cache_err), .o_irq(irq),
    .o_enh_size_kb(enh_size), .o_enh_max_kb(enh_max));

  // 50 MHz device clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Compare any port value
  task automatic chk_sig(input string nm, input logic [39:0] exp, input logic [39:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %0h got %0h", nm, exp, got);
    end
  endtask

  // Compare a register byte
  task automatic chk_reg(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %0h got %0h", nm, exp, got);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge ref_clk);
    wr_stb  <= 1'b0;
  endtask

  // One-cycle read; data sampled in the following cycle only
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
    @(posedge ref_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(negedge ref_clk);
    rdata = rd_data & m;
    chk_reg($sformatf("reg_%0h", a), exp, rdata);
  endtask

  // Media side: wait for a commit, stall dly cycles, then accept
  task automatic take(input logic [7:0] tg, input logic dir, input logic err, input int dly);
    int n;
    n = 0;
    // Start off the clock edge so no output is read as it launches
    @(negedge ref_clk);
    while (c_valid !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    chk_sig("commit_tag", {31'h0, 1'b1, tg}, {31'h0, c_valid, c_tag});
    chk_sig("commit_direct", {39'h0, dir}, {39'h0, c_direct});
    repeat (dly) @(posedge ref_clk);
    @(posedge ref_clk);
    c_ready <= 1'b1;
    c_err   <= err;
    @(posedge ref_clk);
    c_ready <= 1'b0;
    c_err   <= 1'b0;
    @(negedge ref_clk);
  endtask

  // Verdict and end of run
  task automatic tally_and_finish();
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard, far beyond the expected run
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    errors = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    {addr, wr_data, wr_stb, rd_stb, c_ready, c_err} = '0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd_chk(`OFF_FENCE_CAP, 8'h01);
    rd_chk(`OFF_POLICY, `POLICY_VALUE);
    wr(`OFF_POLICY, 8'hFE);
    rd_chk(`OFF_POLICY, `POLICY_VALUE);
    rd_chk(`OFF_CACHE_CTRL, 8'h00);
    rd_chk(`OFF_FLUSH_TRIG, 8'h00);
    rd_chk(9'h1FF, 8'h00);
    host.frame(1'b1, 8'h11, 1'b0, 1'b0);
    take(8'h11, 1'b1, 1'b0, 0);
    wr(`OFF_IRQ_EN, 8'h0F);
    wr(`OFF_IRQ_CLR, 8'h0F);
    wr(`OFF_CACHE_CTRL, 8'h01);
    rd_chk(`OFF_CACHE_CTRL, 8'h01);
    host.frame(1'b1, 8'hA1, 1'b0, 1'b0);
    host.frame(1'b1, 8'hA2, 1'b0, 1'b0);
    repeat (20) @(negedge ref_clk);
    chk_sig("held_in_cache", 40'h0, {39'h0, c_valid});
    host.frame(1'b1, 8'hF0, 1'b1, 1'b0);
    take(8'hF0, 1'b1, 1'b0, 3);
    wr(`OFF_FENCE_EN, 8'h01);
    wr(`OFF_FLUSH_TRIG, 8'h02);
    wr(`OFF_CACHE_CTRL, 8'h00);
    take(8'hA1, 1'b0, 1'b0, 4);
    take(8'hA2, 1'b0, 1'b1, 0);
    repeat (4) @(negedge ref_clk);
    chk_sig("cache_err", 40'h1, {39'h0, cache_err});
    rd_chk(`OFF_IRQ_STAT, 8'h07);
    chk_sig("irq", 40'h1, {39'h0, irq});
    wr(`OFF_IRQ_EN, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk_sig("irq_masked", 40'h0, {39'h0, irq});
    wr(`OFF_IRQ_EN, 8'h0F);
    wr(`OFF_IRQ_CLR, 8'h0F);
    rd_chk(`OFF_IRQ_STAT, 8'h00);
    chk_sig("irq_clear", 40'h0, {39'h0, irq});
    wr(`OFF_FENCE_EN, 8'h00);
    wr(`OFF_FLUSH_TRIG, 8'h02);
    rd_chk(`OFF_IRQ_STAT, 8'h00);
    wr(`OFF_FENCE_EN, 8'h01);
    wr(`OFF_CACHE_CTRL, 8'h01);
    host.frame(1'b1, 8'h6B, 1'b0, 1'b0);
    repeat (3) wr(`OFF_FLUSH_TRIG, 8'h02);
    rd_chk(`OFF_IRQ_STAT, 8'h08, 8'h08);
    take(8'h6B, 1'b0, 1'b0, 0);
    // Overfill the cache: the full cache must drain its oldest entry
    for (int i = 0; i < 17; i++) begin
      host.frame(1'b1, 8'hC0 + 8'(i), 1'b0, 1'b0);
    end
    chk_sig("cache_full", 40'h1, {39'h0, c_valid});
    wr(`OFF_CACHE_CTRL, 8'h00);
    for (int i = 0; i < 17; i++) begin
      take(8'hC0 + 8'(i), 1'b0, 1'b0, 0);
    end
    wr(`OFF_CACHE_CTRL, 8'h01);
    host.pin_reset();
    repeat (6) @(negedge ref_clk);
    rd_chk(`OFF_CACHE_CTRL, 8'h00);
    wr(`OFF_CACHE_CTRL, 8'h01);
    host.frame(1'b0, 8'h00, 1'b0, 1'b1);
    repeat (6) @(negedge ref_clk);
    rd_chk(`OFF_CACHE_CTRL, 8'h00);
    host.frame(1'b1, 8'h5A, 1'b0, 1'b0);
    host.frame(1'b1, 8'h5B, 1'b0, 1'b0);
    chk_sig("link_busy", 40'h1, {39'h0, link_busy});
    take(8'h5A, 1'b1, 1'b0, 0);
    take(8'h5B, 1'b1, 1'b0, 0);
    chk_sig("link_idle", 40'h0, {39'h0, link_busy});
    wr(`OFF_ENH_MULT, 8'h03);
    rd_chk(`OFF_ENH_MULT, 8'h03);
    chk_sig("enh_size", 40'h0000002400, enh_size);
    chk_sig("enh_max", 40'h000000C000, enh_max);
    tally_and_finish();
  end
endmodule // tb_flash_write_cache

`default_nettype wire
